// ===== design/swm_code_sel.sv
// picks the lowest-numbered active warning and returns its code
// assumes: warning vector ordered by code, index 0 is the lowest code
`timescale 1ns/1ps
`include "swm_regs.svh"

module swm_code_sel
    import swm_pkg::*;
(
    input wire logic [`SWM_NWARN-1:0] warn,
    output logic [`SWM_CODE_W-1:0] code,
    output logic any
);

    // ------------------------------------------------------------
    // index to code table
    // ------------------------------------------------------------
    function automatic logic [`SWM_CODE_W-1:0] code_of(input int i);
        case (i)
            0: code_of = `SWM_C_900;
            1: code_of = `SWM_C_901;
            2: code_of = `SWM_C_910;
            3: code_of = `SWM_C_911;
            4: code_of = `SWM_C_920;
            5: code_of = `SWM_C_921;
            6: code_of = `SWM_C_930;
            7: code_of = `SWM_C_94A;
            8: code_of = `SWM_C_94B;
            9: code_of = `SWM_C_94C;
            10: code_of = `SWM_C_94D;
            11: code_of = `SWM_C_94E;
            12: code_of = `SWM_C_95A;
            13: code_of = `SWM_C_95B;
            14: code_of = `SWM_C_95D;
            15: code_of = `SWM_C_95E;
            16: code_of = `SWM_C_95F;
            17: code_of = `SWM_C_960;
            18: code_of = `SWM_C_971;
            19: code_of = `SWM_C_97A;
            20: code_of = `SWM_C_97B;
            21: code_of = `SWM_C_9A0;
            22: code_of = `SWM_C_9B0;
            default: code_of = `SWM_C_NONE;
        endcase
    endfunction

    // ------------------------------------------------------------
    // priority pick, lowest index wins
    // ------------------------------------------------------------
    always_comb begin
        code = `SWM_C_NONE;
        any = 1'b0;
        for (int i = `SWM_NWARN - 1; i >= 0; i--) begin
            if (warn[i]) begin
                code = code_of(i);
                any = 1'b1;
            end
        end
    end

endmodule

// ===== design/swm_pkg.sv
// types shared by the warning monitor modules
// assumes: swm_regs.svh is on the include path
`include "swm_regs.svh"

package swm_pkg;

    // ------------------------------------------------------------
    // control register layout
    // ------------------------------------------------------------
    typedef struct packed {
        logic comm_mask;
        logic maint_enable;
        logic overtravel_enable;
        logic vib_as_warning;
        logic uv_as_warning;
        logic batt_as_warning;
        logic global_detect;
        logic code_output;
        logic legacy_profile;
    } swm_ctrl_type;

    // ------------------------------------------------------------
    // causes from the drive and the command interpreter
    // ------------------------------------------------------------
    typedef struct packed {
        logic [`SWM_DEV_W-1:0] dev_abs;
        logic servo_on;
        logic overload_pre;
        logic regen_pre;
        logic brake_pre;
        logic vibration_det;
        logic battery_low;
        logic undervolt_pre;
        logic overtravel_det;
        logic maint_due;
        logic [4:0] data_warn;
        logic [4:0] cmd_warn;
        logic layer_warn;
        logic clamp_warn;
        logic comm_fail;
        logic valid_cmd;
        logic clear_alarm_warning_cmd;
    } swm_cause_type;

    // ------------------------------------------------------------
    // bus phase tracking
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SWM_BUS_IDLE = 3'b001,
        SWM_BUS_WRITE = 3'b010,
        SWM_BUS_READ = 3'b100
    } swm_bus_type;

    // ------------------------------------------------------------
    // all state of the top module
    // ------------------------------------------------------------
    typedef struct packed {
        swm_ctrl_type ctrl;
        logic [`SWM_DEV_W-1:0] excess_level;
        logic [`SWM_PCT_W-1:0] dev_pct;
        logic [`SWM_PCT_W-1:0] son_pct;
        logic [`SWM_DEV_W-1:0] son_level;
        logic [`SWM_NWARN-1:0] warn;
        swm_bus_type bus;
        logic [`SWM_AW-1:0] addr;
        logic [31:0] rdata;
        logic hreadyout;
        logic [`SWM_CODE_W-1:0] panel_code;
        logic panel_active;
        logic [`SWM_CODE_W-1:0] code_out;
        logic code_out_valid;
    } swm_state_type;

endpackage

// ===== design/swm_regs.svh
// register map, field positions, reset values and warning codes
// assumes: included by every file that uses its names
`ifndef SWM_REGS_SVH
`define SWM_REGS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define SWM_DEV_W 28
`define SWM_PCT_W 8
`define SWM_NWARN 23
`define SWM_CODE_W 12
`define SWM_AW 8

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SWM_OFS_CTRL 8'h00
`define SWM_OFS_EXCESS 8'h04
`define SWM_OFS_PCT 8'h08
`define SWM_OFS_SON_LEVEL 8'h0C
`define SWM_OFS_STATUS 8'h10
`define SWM_OFS_CODE 8'h14
`define SWM_OFS_CMD 8'h18

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define SWM_CTRL_W 9
`define SWM_CTRL_RST 9'h004
`define SWM_CMD_CLEAR_BIT 0
`define SWM_PCT_DEV_LSB 0
`define SWM_PCT_SON_LSB 8
`define SWM_EXCESS_RST 28'h0000000
`define SWM_PCT_RST 8'h00
`define SWM_SON_LEVEL_RST 28'h0000000
`define SWM_PERCENT_DIV 8'h64

// ----------------------------------------------------------------
// warning groups, one bit per warning index
// ----------------------------------------------------------------
`define SWM_MASK_AUTO 23'h19F780
`define SWM_MASK_LEVEL 23'h400008
`define SWM_MASK_COMM 23'h1BFF80
`define SWM_MASK_GLOBAL 23'h000037

// ----------------------------------------------------------------
// warning codes as shown on the panel, three hex digits
// ----------------------------------------------------------------
`define SWM_C_900 12'h900
`define SWM_C_901 12'h901
`define SWM_C_910 12'h910
`define SWM_C_911 12'h911
`define SWM_C_920 12'h920
`define SWM_C_921 12'h921
`define SWM_C_930 12'h930
`define SWM_C_94A 12'h94A
`define SWM_C_94B 12'h94B
`define SWM_C_94C 12'h94C
`define SWM_C_94D 12'h94D
`define SWM_C_94E 12'h94E
`define SWM_C_95A 12'h95A
`define SWM_C_95B 12'h95B
`define SWM_C_95D 12'h95D
`define SWM_C_95E 12'h95E
`define SWM_C_95F 12'h95F
`define SWM_C_960 12'h960
`define SWM_C_971 12'h971
`define SWM_C_97A 12'h97A
`define SWM_C_97B 12'h97B
`define SWM_C_9A0 12'h9A0
`define SWM_C_9B0 12'h9B0
`define SWM_C_NONE 12'h000

`endif

// ===== design/swm_threshold.sv
// deviation compare: dev > level * percent / 100, without a divider
// assumes: operands static for the cycle, combinational result
`timescale 1ns/1ps
`include "swm_regs.svh"

module swm_threshold
    import swm_pkg::*;
#(
    parameter int DEV_W = 28,
    parameter int PCT_W = 8
) (
    input wire logic [DEV_W-1:0] dev,
    input wire logic [DEV_W-1:0] level,
    input wire logic [PCT_W-1:0] pct,
    output logic over
);

    localparam int PW = DEV_W + PCT_W;

    // ------------------------------------------------------------
    // scaled compare
    // ------------------------------------------------------------
    function automatic logic exceeds(input logic [DEV_W-1:0] d,
                                     input logic [DEV_W-1:0] l,
                                     input logic [PCT_W-1:0] p);
        logic [PW-1:0] lhs;
        logic [PW-1:0] rhs;
        lhs = PW'(d) * PW'(`SWM_PERCENT_DIV);
        rhs = PW'(l) * PW'(p);
        exceeds = lhs > rhs;
    endfunction

    always_comb begin
        over = exceeds(dev, level, pct);
    end

endmodule

// ===== design/swm_top.sv
// servo warning monitor: detection, latching, clearing, code display
// assumes: AHB-Lite single slave, causes synchronous to hclk
//
// Contract
// - active warning code is shown on the panel, ahead of the fault
// - A.900 when deviation exceeds excess level times percent / 100
// - A.901 while servo on, deviation above servo-on level share
// - A.910 latched on overload pre-alarm until reset
// - A.920 regeneration and A.921 braking pre-alarm, both latched
// - A.911 on vibration when vibration select picks warning
// - A.930 on low battery when its select digit picks warning
// - A.94A to A.94D data-setting warnings from command checks
// - A.94E latch exception, cleared only by explicit reset
// - A.95A A.95B A.95D A.95E A.95F command warnings
// - A.97A for a command not executable in current layer
// - A.97b when command data was clamped to its limits
// - A.960 on communication failure, needs explicit reset
// - A.9A0 on overtravel while servo on, own enable only
// - auto-reset warnings clear on next valid command, new profile
// - legacy profile clears warnings only on the clear command
// - code outputs carry warning codes only when code output set
// - global detect digit gates A.900, A.901, A.910, A.920, A.921
// - communication mask digit gates A.94A to A.960, A.97A, A.97b
// - A.971 on undervoltage pre-alarm when its digit selects warning
// - A.9b0 maintenance warning enabled by its select bit
//
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "swm_regs.svh"

module swm_top
    import swm_pkg::*;
#(
    parameter int DEV_W = `SWM_DEV_W,
    parameter int PCT_W = `SWM_PCT_W
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire swm_cause_type cause,
    output logic [`SWM_CODE_W-1:0] panel_code,
    output logic panel_active,
    output logic [`SWM_CODE_W-1:0] code_out,
    output logic code_out_valid
);

    swm_state_type s_q;
    swm_state_type s_d;
    logic dev_over;
    logic son_over;
    logic [`SWM_CODE_W-1:0] sel_code;
    logic sel_any;

    // ------------------------------------------------------------
    // deviation compares
    // ------------------------------------------------------------
    swm_threshold #(
        .DEV_W(DEV_W),
        .PCT_W(PCT_W)
    ) u_dev_thr (
        .dev(cause.dev_abs),
        .level(s_q.excess_level),
        .pct(s_q.dev_pct),
        .over(dev_over)
    );

    swm_threshold #(
        .DEV_W(DEV_W),
        .PCT_W(PCT_W)
    ) u_son_thr (
        .dev(cause.dev_abs),
        .level(s_q.son_level),
        .pct(s_q.son_pct),
        .over(son_over)
    );

    // ------------------------------------------------------------
    // code selection from the next-state warnings, s_d.warn
    // ------------------------------------------------------------
    swm_code_sel u_sel (
        .warn(s_d.warn),
        .code(sel_code),
        .any(sel_any)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic [`SWM_NWARN-1:0] raw;
    logic [`SWM_NWARN-1:0] en;
    logic [`SWM_NWARN-1:0] set;
    logic [`SWM_NWARN-1:0] clr;
    logic sw_clear;
    logic take;
    logic [31:0] rd;

    always_comb begin
        s_d = s_q;
        raw = '0;
        en = '1;
        set = '0;
        clr = '0;
        sw_clear = 1'b0;
        rd = 32'h00000000;
        take = hsel & htrans[1] & hready;

        // bus write data phase
        if (s_q.bus == SWM_BUS_WRITE) begin
            case (s_q.addr)
                `SWM_OFS_CTRL: begin
                    s_d.ctrl = swm_ctrl_type'(hwdata[`SWM_CTRL_W-1:0]);
                end
                `SWM_OFS_EXCESS: begin
                    s_d.excess_level = hwdata[DEV_W-1:0];
                end
                `SWM_OFS_PCT: begin
                    s_d.dev_pct = hwdata[`SWM_PCT_DEV_LSB +: PCT_W];
                    s_d.son_pct = hwdata[`SWM_PCT_SON_LSB +: PCT_W];
                end
                `SWM_OFS_SON_LEVEL: begin
                    s_d.son_level = hwdata[DEV_W-1:0];
                end
                `SWM_OFS_CMD: begin
                    sw_clear = hwdata[`SWM_CMD_CLEAR_BIT];
                end
                default: begin
                end
            endcase
        end

        // raw causes by warning index
        raw[0] = dev_over;
        raw[1] = son_over & cause.servo_on;
        raw[2] = cause.overload_pre;
        raw[3] = cause.vibration_det;
        raw[4] = cause.regen_pre;
        raw[5] = cause.brake_pre;
        raw[6] = cause.battery_low;
        raw[10:7] = cause.data_warn[3:0];
        raw[11] = cause.data_warn[4];
        raw[16:12] = cause.cmd_warn;
        raw[17] = cause.comm_fail;
        raw[18] = cause.undervolt_pre;
        raw[19] = cause.layer_warn;
        raw[20] = cause.clamp_warn;
        raw[21] = cause.overtravel_det & cause.servo_on;

        raw[22] = cause.maint_due;

        // detection enables
        if (!s_q.ctrl.global_detect) begin
            en = en & ~`SWM_MASK_GLOBAL;
        end
        if (s_q.ctrl.comm_mask) begin
            en = en & ~`SWM_MASK_COMM;
        end
        en[3] = s_q.ctrl.vib_as_warning;
        en[6] = s_q.ctrl.batt_as_warning;
        en[18] = s_q.ctrl.uv_as_warning;
        en[21] = s_q.ctrl.overtravel_enable;
        en[22] = s_q.ctrl.maint_enable;
        set = raw & en;

        // clearing, a new event wins over a clear in the same cycle
        if (cause.clear_alarm_warning_cmd | sw_clear) begin
            clr = ~`SWM_MASK_LEVEL;
        end else if (!s_q.ctrl.legacy_profile & cause.valid_cmd) begin
            clr = `SWM_MASK_AUTO;
        end
        s_d.warn = (((s_q.warn & ~clr) | set) & ~`SWM_MASK_LEVEL)
                 | (set & `SWM_MASK_LEVEL);

        // displayed and output codes
        s_d.panel_code = sel_code;
        s_d.panel_active = sel_any;
        if (s_q.ctrl.code_output) begin
            s_d.code_out = sel_code;
            s_d.code_out_valid = sel_any;
        end else begin
            s_d.code_out = `SWM_C_NONE;
            s_d.code_out_valid = 1'b0;
        end

        // bus address phase, read data prepared for the data phase
        case (haddr[`SWM_AW-1:0])
            `SWM_OFS_CTRL: rd = 32'(s_q.ctrl);
            `SWM_OFS_EXCESS: rd = 32'(s_q.excess_level);
            `SWM_OFS_PCT: rd = {16'h0000, s_q.son_pct, s_q.dev_pct};
            `SWM_OFS_SON_LEVEL: rd = 32'(s_q.son_level);
            `SWM_OFS_STATUS: rd = 32'(s_q.warn);
            `SWM_OFS_CODE: rd = 32'({s_q.panel_active, s_q.panel_code});
            default: rd = 32'h00000000;
        endcase
        s_d.hreadyout = 1'b1;
        s_d.rdata = 32'h00000000;
        if (take) begin
            s_d.addr = haddr[`SWM_AW-1:0];
            s_d.bus = hwrite ? SWM_BUS_WRITE : SWM_BUS_READ;
            if (!hwrite) begin
                s_d.rdata = rd;
            end
        end else begin
            s_d.bus = SWM_BUS_IDLE;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q.ctrl <= swm_ctrl_type'(`SWM_CTRL_RST);
            s_q.excess_level <= `SWM_EXCESS_RST;
            s_q.dev_pct <= `SWM_PCT_RST;
            s_q.son_pct <= `SWM_PCT_RST;
            s_q.son_level <= `SWM_SON_LEVEL_RST;
            s_q.warn <= '0;
            s_q.bus <= SWM_BUS_IDLE;
            s_q.addr <= '0;
            s_q.rdata <= 32'h00000000;
            s_q.hreadyout <= 1'b1;
            s_q.panel_code <= `SWM_C_NONE;
            s_q.panel_active <= 1'b0;
            s_q.code_out <= `SWM_C_NONE;
            s_q.code_out_valid <= 1'b0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign hrdata = s_q.rdata;
    assign hreadyout = s_q.hreadyout;
    assign hresp = 1'b0;
    assign panel_code = s_q.panel_code;
    assign panel_active = s_q.panel_active;
    assign code_out = s_q.code_out;
    assign code_out_valid = s_q.code_out_valid;

endmodule

// ===== tb/swm_host_model.sv
// host model: command pulses on the cause word
// assumes: one pulse per send
`timescale 1ns/1ps

module swm_host_model
    import swm_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic send,
    input wire logic [1:0] kind,
    input wire logic [12:0] warn_bits,
    output swm_cause_type host_cause
);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            host_cause <= '0;
        end else begin
            host_cause <= '0;
            if (send && kind == 2'd0) host_cause.valid_cmd <= 1'b1;
            if (send && kind == 2'd1) begin
                host_cause.clear_alarm_warning_cmd <= 1'b1;
            end
            if (send && kind == 2'd2) begin
                host_cause.data_warn <= warn_bits[4:0];
                host_cause.cmd_warn <= warn_bits[9:5];
                host_cause.layer_warn <= warn_bits[10];
                host_cause.clamp_warn <= warn_bits[11];
                host_cause.comm_fail <= warn_bits[12];
            end
        end
    end
endmodule

// ===== tb/swm_top_properties.sv
// checker on the warning monitor ports
// assumes: bound into swm_top, clock hclk
`timescale 1ns/1ps
`include "swm_regs.svh"

module swm_top_properties
    import swm_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire swm_cause_type cause,
    input wire logic [`SWM_CODE_W-1:0] panel_code,
    input wire logic panel_active,
    input wire logic [`SWM_CODE_W-1:0] code_out,
    input wire logic code_out_valid
);
    logic wr_q, rd_q, take, clr, quiet;
    logic [7:0] adr_q;
    logic [8:0] ctrl_q;
    assign take = hsel && htrans[1] && hready && ce;
    assign clr = cause.clear_alarm_warning_cmd
        || (wr_q && adr_q == 8'h18 && hwdata[0]);
    // every cause but servo_on and the two host command pulses
    assign quiet = (cause & 52'hFFFFFFF7FFFFC) == '0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            adr_q <= 8'h00;
            ctrl_q <= 9'h004;
        end else if (ce) begin
            wr_q <= take && hwrite;
            rd_q <= take && !hwrite;
            if (take) adr_q <= haddr[7:0];
            if (wr_q && adr_q == 8'h00) ctrl_q <= hwdata[8:0];
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus answer bad");
    AST_RDATA_CTRL: assert property (rd_q && adr_q == 8'h00
        |-> hrdata == {23'h0, ctrl_q})
        else $error("ctrl readback");
    AST_RDATA_IDLE: assert property (!rd_q |-> hrdata == 32'h0)
        else $error("stray read data");
    AST_PANEL_ACTIVE: assert property (panel_active == (panel_code != 0))
        else $error("panel active");
    AST_CODE_OUT: assert property (code_out_valid ?
        (panel_active && code_out == panel_code) : code_out == 12'h000)
        else $error("code gating");
    AST_OVERLOAD: assert property (ce && cause.overload_pre && ctrl_q[2]
        |=> panel_active && panel_code <= 12'h910)
        else $error("overload missed");
    AST_REGEN: assert property (ce && ctrl_q[2]
        && (cause.regen_pre || cause.brake_pre)
        |=> panel_active && panel_code <= 12'h921)
        else $error("regen missed");
    AST_VIBRATION: assert property (ce && ctrl_q[5]
        && cause.vibration_det |=> panel_active && panel_code <= 12'h911)
        else $error("vibration missed");
    AST_OVERTRAVEL: assert property (ce && cause.overtravel_det
        && cause.servo_on && ctrl_q[6]
        |=> panel_active && panel_code <= 12'h9A0)
        else $error("overtravel missed");
    AST_COMM_FAIL: assert property (ce && cause.comm_fail
        && !ctrl_q[8] |=> panel_active && panel_code <= 12'h960)
        else $error("comm missed");
    AST_LATCH_HOLD: assert property (ce && panel_code == 12'h910 && !clr
        && quiet |=> panel_code == 12'h910)
        else $error("latch dropped");
    AST_CLEAR: assert property (ce && clr && quiet |=> !panel_active)
        else $error("clear failed");
    AST_RAISE_CAUSE: assert property ($rose(panel_active)
        |-> $past(quiet) == 1'b0)
        else $error("causeless raise");

    COV_CLEAR: cover property (clr && panel_active);
    COV_STATUS_READ: cover property (rd_q && adr_q == 8'h10);
    COV_DATA_WARN: cover property (panel_code == 12'h94A);
endmodule

bind swm_top swm_top_properties u_swm_top_properties (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cause(cause),
    .panel_code(panel_code), .panel_active(panel_active),
    .code_out(code_out), .code_out_valid(code_out_valid)
);

// ===== tb/swm_top_tb.sv
// bench: registers, thresholds, causes, host commands
// assumes: swm_top and the host model
`timescale 1ns/1ps
`include "swm_regs.svh"

module swm_top_tb
    import swm_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0] htrans = 2'b00;
    logic hreadyout, hresp, panel_active, code_out_valid;
    logic [11:0] panel_code, code_out;
    swm_cause_type cb = '0, hc, cause;
    logic send = 1'b0;
    logic [1:0] kind = 2'b00;
    logic [12:0] wbits = '0;
    int num_errors = 0, num_checks = 0;
    logic [31:0] rng = 32'h3;
    logic [11:0] codes [23] = '{12'h900, 12'h901, 12'h910, 12'h911,
        12'h920, 12'h921, 12'h930, 12'h94A, 12'h94B, 12'h94C, 12'h94D,
        12'h94E, 12'h95A, 12'h95B, 12'h95D, 12'h95E, 12'h95F, 12'h960,
        12'h971, 12'h97A, 12'h97B, 12'h9A0, 12'h9B0};
    int ix [8] = '{2, 4, 5, 6, 18, 3, 21, 22};
    int en [8] = '{2, 2, 2, 3, 4, 5, 6, 7};
    int pos [8] = '{22, 21, 20, 18, 17, 19, 16, 15};

    always #2.5 hclk = ~hclk;
    assign cause = swm_cause_type'(cb | hc);

    swm_top u_swm_top (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .cause(cause), .panel_code(panel_code),
        .panel_active(panel_active), .code_out(code_out),
        .code_out_valid(code_out_valid));
    swm_host_model u_swm_host_model (.hclk(hclk), .hresetn(hresetn),
        .send(send), .kind(kind), .warn_bits(wbits), .host_cause(hc));

    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    function automatic logic [22:0] warn_map(input logic [12:0] b);
        return {2'b00, b[11], b[10], 1'b0, b[12], b[9:0], 7'h00};
    endfunction

    function automatic logic [11:0] low_code(input logic [22:0] m);
        for (int i = 0; i < 23; i++) begin
            if (m[i]) return codes[i];
        end
        return 12'h000;
    endfunction

    task automatic close_out;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_ready;
        for (int n = 0; n < 17; n++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) return;
        end
        num_errors++;
        close_out();
    endtask

    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        wait_ready();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    task automatic pulse(input swm_cause_type c);
        swm_cause_type k;
        k = '0;
        k.servo_on = c.servo_on;
        @(posedge hclk);
        cb <= c;
        @(posedge hclk);
        cb <= k;
        @(negedge hclk);
    endtask

    task automatic host_send(input logic [1:0] k, input logic [12:0] b);
        @(posedge hclk);
        send <= 1'b1;
        kind <= k;
        wbits <= b;
        @(posedge hclk);
        send <= 1'b0;
        @(posedge hclk);
        @(negedge hclk);
    endtask

    initial begin
        #400000;
        num_errors++;
        close_out();
    end

    initial begin
        swm_cause_type c;
        logic [31:0] r, lvl;
        logic [7:0] pct;
        logic [63:0] lp, dv;
        logic e;
        logic [12:0] b;
        logic [22:0] m;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(8'h00, 32'h4);
        for (int i = 1; i < 6; i++) rdc(8'(4 * i), 32'h0);
        rdc(8'h40, 32'h0);
        r = xs();
        ahb(1'b1, 8'h04, r);
        rdc(8'h04, r & 32'h0FFFFFFF);
        ahb(1'b1, 8'h10, r);
        rdc(8'h10, 32'h0);
        ahb(1'b1, 8'h40, r);
        rdc(8'h40, 32'h0);
        ahb(1'b1, 8'h00, 32'h4);
        for (int t = 0; t < 6; t++) begin
            lvl = xs() & 32'h000FFFFF;
            r = xs();
            pct = (t == 0) ? 8'h00 : r[7:0];
            lp = 64'(lvl) * pct;
            dv = lp / 100 + t % 2;
            e = (dv * 100 > lp);
            c = '0;
            c.dev_abs = dv[27:0];
            c.servo_on = r[9];
            ahb(1'b1, 8'h04, lvl);
            ahb(1'b1, 8'h08, {16'h0, pct, pct});
            ahb(1'b1, 8'h0C, lvl);
            pulse(c);
            check(panel_code, e ? 12'h900 : 12'h000);
            check(code_out, 12'h000);
            rdc(8'h10, {30'h0, e & r[9], e});
            host_send(2'd1, 13'h0);
            rdc(8'h10, 32'h0);
        end
        for (int k = 0; k < 8; k++) begin
            for (int on = 0; on < 2; on++) begin
                ahb(1'b1, 8'h00, on ? (32'h1 << en[k]) | 32'h2 : 32'h2);
                c = '0;
                c.servo_on = 1'b1;
                c[pos[k]] = 1'b1;
                pulse(c);
                r = on ? codes[ix[k]] : 12'h000;
                check(panel_code, r);
                check(code_out, r);
                e = on && ix[k] != 3 && ix[k] != 22;
                rdc(8'h10, e ? 32'h1 << ix[k] : 32'h0);
                ahb(1'b1, 8'h18, 32'h1);
                rdc(8'h10, 32'h0);
            end
        end
        ahb(1'b1, 8'h00, 32'h4);
        for (int t = 0; t < 4; t++) begin
            r = xs();
            b = (t == 0) ? 13'h1FFF : r[12:0] | 13'h1;
            m = warn_map(b);
            host_send(2'd2, b);
            rdc(8'h10, m);
            check(panel_code, low_code(m));
            rdc(8'h14, {19'h0, 1'b1, low_code(m)});
            host_send(2'd0, 13'h0);
            rdc(8'h10, m & ~`SWM_MASK_AUTO);
            ahb(1'b1, 8'h18, 32'h1);
        end
        ahb(1'b1, 8'h00, 32'h5);
        host_send(2'd2, 13'h1FFF);
        host_send(2'd0, 13'h0);
        rdc(8'h10, warn_map(13'h1FFF));
        host_send(2'd1, 13'h0);
        rdc(8'h10, 32'h0);
        ahb(1'b1, 8'h00, 32'h104);
        host_send(2'd2, 13'h1FFF);
        rdc(8'h10, 32'h0);
        close_out();
    end
endmodule
